// *** verilog/spi_port.sv ***
// spi half of the shared serial module: registers, master and slave shifter
//
// Summary of operation
// - master codes 000..011 pick system clock /4, /16, /64 or sub clock
// - code 100 is master clocked at half the timer match rate
// - 101 slave from external clock; 110 two-wire; 111 serial function off
// - enable low releases all pins and stops the shifter
// - enabling again keeps the control register contents
// - slave select rising mid byte sets incomplete and complete flags
// - software setting the incomplete flag does not set the complete flag
// - idle level bit 0 idles sck high, 1 idles sck low
// - edge bit with polarity picks rising or falling sample edge
// - order bit 1 shifts msb first, 0 lsb first
// - select pin enable 0 ignores the select pin, 1 uses it
// - data write during transfer is dropped and sets collision flag
// - complete flag set at end of transfer, cleared by software
// - master data write starts full duplex byte transfer at once
// - slave shifts data out on sdo and sdi into same register
// - slave without select pin enable is always selected
// - logic keeps running in idle while its clock source runs
// - data register is eight bit read write, shared both ways
// - two spare format bits are plain read write storage
// - mode register bit 4 reads zero
// - enabled idle: sdi floats; a selected slave drives bit one on sdo, else sdo high when select pin enable is 1 (released when 0); master sck at idle level
`timescale 1ns/1ps
`include "spi_port_consts.svh"
module spi_port
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic sub_tick_i,
    input wire logic tmr_tick_i,
    input wire spi_port_pkg::pin_in_t pins_i,
    output spi_port_pkg::pin_out_t pins_o,
    output logic ss_used_o,
    output logic busy_o
);
    ////////////////////////////////////////////////////////////////////////////
    // register bus
    logic bus_wr;
    logic bus_rd;
    logic [7:0] data_ff;
    logic [7:0] mode_ff;
    logic [7:0] fmt_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] wbyte;
    wb_byte_regs u_bus
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .sel_i(sel_i[0]),
        .ack_o(ack_o),
        .wr_o(bus_wr),
        .rd_o(bus_rd)
    );
    assign wbyte = dat_i[7:0];
    // field views
    spi_port_pkg::op_mode_t op_mode;
    logic enable;
    logic pol;
    logic edge_sel;
    logic msb_first;
    logic select_pin_enable;
    logic is_master;
    logic is_slave;
    assign op_mode = spi_port_pkg::op_mode_t'(mode_ff[`MODE_FLD_HI:`MODE_FLD_LO]);
    assign enable = mode_ff[`MODE_EN_BIT];
    assign pol = fmt_ff[`FMT_POL_BIT];
    assign edge_sel = fmt_ff[`FMT_EDGE_BIT];
    assign msb_first = fmt_ff[`FMT_ORDER_BIT];
    assign select_pin_enable = fmt_ff[`FMT_SELECT_PIN_ENABLE_BIT];
    // codes 110 and 111 leave the spi logic idle
    assign is_master = enable && (op_mode <= spi_port_pkg::MODE_TMR);
    assign is_slave = enable && (op_mode == spi_port_pkg::MODE_SLAVE);
    wire wr_data = bus_wr && (adr_i == `OFS_DATA);
    wire wr_mode = bus_wr && (adr_i == `OFS_MODE);
    wire wr_fmt = bus_wr && (adr_i == `OFS_FMT);
    ////////////////////////////////////////////////////////////////////////////
    // shifter state
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} xfer_st_t;
    xfer_st_t st_ff;
    logic [3:0] bit_cnt_ff;
    logic sck_ff;
    logic half_tick;
    logic done_pulse;
    logic abort_pulse;
    logic slave_sel;
    logic slave_sample;
    logic slave_shift;
    logic sck_d_ff;
    logic ss_d_ff;
    logic slave_act_ff;
    logic in_bit_ff;
    logic master_sample;
    logic master_shift;
    logic master_end;
    logic [3:0] last_cnt;
    logic fin_ff;
    wire idle_lvl = !pol;
    // sample edge is rising when polarity bit equals edge bit
    // edge bit 1: the first sck edge of each bit samples, the second shifts
    // edge bit 0: the second sck edge samples, the first shifts (but not for
    // bit one, whose value already stands on sdo before any edge)
    // the far side sees our sck one clock late, so sdo never moves on a
    // sample tick; it moves on the opposite edge only
    wire sample_rise = (pol == edge_sel);
    // fin_ff keeps busy up for the extra clock that edge bit 0 needs
    wire xfer_busy = (st_ff != ST_IDLE) || slave_act_ff || fin_ff;
    assign busy_o = xfer_busy;
    shift_rate_gen u_rate
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(is_master && (st_ff != ST_IDLE)),
        .mode_i(op_mode),
        .sub_tick_i(sub_tick_i),
        .tmr_tick_i(tmr_tick_i),
        .half_tick_o(half_tick)
    );
    // master sequencing: edge bit 1 lead half samples, trail half shifts; edge bit 0 swaps them
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !is_master)
            st_ff <= ST_IDLE;
        else
        begin
            case (st_ff)
                ST_IDLE: if (wr_data) st_ff <= ST_LEAD;
                ST_LEAD: if (half_tick) st_ff <= ST_TRAIL;
                ST_TRAIL:
                    if (half_tick)
                        st_ff <= master_end ? ST_IDLE : ST_LEAD;
                default: st_ff <= ST_IDLE;
            endcase
        end
    end
    // sck out: toggles each half tick, rests at idle level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sck_ff <= 1'b1;
        else if (st_ff == ST_IDLE)
            sck_ff <= idle_lvl;
        else if (half_tick)
            sck_ff <= !sck_ff;
    end
    // slave edge detect on synchronous pin samples
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sck_d_ff <= 1'b0;
            ss_d_ff <= 1'b1;
        end
        else
        begin
            sck_d_ff <= pins_i.sck;
            ss_d_ff <= pins_i.ss_n;
        end
    end
    assign slave_sel = is_slave && (!select_pin_enable || !pins_i.ss_n);
    wire sck_rise = pins_i.sck && !sck_d_ff;
    wire sck_fall = !pins_i.sck && sck_d_ff;
    assign slave_sample = slave_sel && (sample_rise ? sck_rise : sck_fall);
    assign slave_shift = slave_sel && (sample_rise ? sck_fall : sck_rise);
    // master edge roles follow the edge bit; the byte ends on the sixteenth
    // sck edge either way, which leaves sck back at its idle level
    always_comb
    begin
        master_sample = 1'b0;
        master_shift = 1'b0;
        if (edge_sel)
        begin
            last_cnt = `BITS_PER_BYTE;
            master_sample = half_tick && (st_ff == ST_LEAD);
            master_shift = half_tick && (st_ff == ST_TRAIL) && (bit_cnt_ff != `BITS_PER_BYTE);
        end
        else
        begin
            last_cnt = `BITS_PER_BYTE - 4'h1;
            master_sample = half_tick && (st_ff == ST_TRAIL);
            master_shift = half_tick && (st_ff == ST_LEAD) && (bit_cnt_ff != 4'h0);
        end
        master_end = half_tick && (st_ff == ST_TRAIL) && (bit_cnt_ff == last_cnt);
    end
    wire do_sample = master_sample || slave_sample;
    wire do_shift = master_shift || (slave_shift && slave_act_ff);
    // slave select rising edge with a partial byte aborts it
    assign abort_pulse = is_slave && select_pin_enable && pins_i.ss_n && !ss_d_ff
        && slave_act_ff;
    wire slave_done = slave_sample && (bit_cnt_ff == `BITS_PER_BYTE - 4'h1);
    // edge bit 0 reports completion one clock after the last sck edge
    assign done_pulse = slave_done || fin_ff || (master_end && edge_sel);
    // slave is busy from first sample until eighth or abort
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !is_slave || abort_pulse || slave_done)
            slave_act_ff <= 1'b0;
        else if (slave_sample)
            slave_act_ff <= 1'b1;
    end
    // bit counter, reset at start of every byte
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !enable || abort_pulse || slave_done)
            bit_cnt_ff <= 4'h0;
        else if ((st_ff == ST_IDLE) && !slave_act_ff && !slave_sample)
            bit_cnt_ff <= 4'h0;
        else if (do_sample)
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
    // sampled bit held until the shift half so sdo stays stable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            in_bit_ff <= 1'b0;
        else if (do_sample)
            in_bit_ff <= pins_i.sdi;
    end
    // edge bit 0 ends on a sample edge: sdo must stand one more clock so the
    // far side can still take the last bit; only then is the sampled bit
    // folded into the byte
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !is_master)
            fin_ff <= 1'b0;
        else
            fin_ff <= master_end && !edge_sel;
    end
    ////////////////////////////////////////////////////////////////////////////
    // data register: one byte shared by transmit and receive
    logic [7:0] shifted;
    // last bit of a slave byte lands at its sample edge
    wire [7:0] sbit = slave_done ? {7'h00, pins_i.sdi} : {7'h00, in_bit_ff};
    always_comb
    begin
        if (msb_first)
            shifted = {data_ff[6:0], sbit[0]};
        else
            shifted = {sbit[0], data_ff[7:1]};
    end
    // power-on value of the data byte is left as zero here
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            data_ff <= 8'h00;
        else if (do_shift || slave_done || fin_ff || (master_end && edge_sel))
            data_ff <= shifted;
        else if (wr_data && !xfer_busy)
            data_ff <= wbyte;
    end
    ////////////////////////////////////////////////////////////////////////////
    // control registers; enable toggles never reset them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_ff[7:1] <= 7'(`MODE_RST >> 1);
        else if (wr_mode)
        begin
            mode_ff[7:5] <= wbyte[7:5];
            mode_ff[4] <= 1'b0;
            mode_ff[3:1] <= wbyte[3:1];
        end
    end
    // incomplete flag: hardware set wins over software clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_ff[`MODE_ICF_BIT] <= 1'b0;
        else if (abort_pulse)
            mode_ff[`MODE_ICF_BIT] <= 1'b1;
        else if (wr_mode)
            mode_ff[`MODE_ICF_BIT] <= wbyte[`MODE_ICF_BIT];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fmt_ff[7:2] <= 6'h00;
        else if (wr_fmt)
            fmt_ff[7:2] <= wbyte[7:2];
    end
    // collision flag set by hardware, software write can set or clear it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fmt_ff[`FMT_WRITE_COLLISION_FLAG_BIT] <= 1'b0;
        else if (wr_data && xfer_busy)
            fmt_ff[`FMT_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
        else if (wr_fmt)
            fmt_ff[`FMT_WRITE_COLLISION_FLAG_BIT] <= wbyte[`FMT_WRITE_COLLISION_FLAG_BIT];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fmt_ff[`FMT_TRF_BIT] <= 1'b0;
        else if (done_pulse || abort_pulse)
            fmt_ff[`FMT_TRF_BIT] <= 1'b1;
        else if (wr_fmt)
            fmt_ff[`FMT_TRF_BIT] <= wbyte[`FMT_TRF_BIT];
    end
    // read data registered at the ack edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rd_data_ff <= 8'h00;
        else if (cyc_i && stb_i && !ack_o)
        begin
            case (adr_i)
                `OFS_DATA: rd_data_ff <= data_ff;
                `OFS_MODE: rd_data_ff <= mode_ff;
                `OFS_FMT: rd_data_ff <= fmt_ff;
                default: rd_data_ff <= 8'h00;
            endcase
        end
    end
    assign dat_o = {24'h000000, rd_data_ff};
    ////////////////////////////////////////////////////////////////////////////
    // pins; no clock gating, so idle modes keep working with clk_i
    always_comb
    begin
        pins_o.sck_o = sck_ff;
        pins_o.sck_oe = is_master;
        // a selected slave must show bit one before the first sck edge,
        // otherwise the master would take the idle high level as data
        pins_o.sdo_o = (xfer_busy || slave_sel) ? (msb_first ? data_ff[7] : data_ff[0]) : 1'b1;
        pins_o.sdo_oe = (is_master || is_slave) && (select_pin_enable || xfer_busy || slave_sel);
    end
    assign ss_used_o = (is_master || is_slave) && select_pin_enable;
    wire unused_ok = bus_rd;
endmodule

// *** verilog/spi_port_consts.svh ***
// register offsets, field positions, reset values and clock divide counts
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH
`define OFS_DATA 2'h0
`define OFS_MODE 2'h1
`define OFS_FMT 2'h2
`define MODE_RST 8'hE0
`define FMT_RST 8'h00
`define MODE_FLD_HI 7
`define MODE_FLD_LO 5
`define MODE_DEB_HI 3
`define MODE_DEB_LO 2
`define MODE_EN_BIT 1
`define MODE_ICF_BIT 0
`define FMT_SPARE_HI 7
`define FMT_SPARE_LO 6
`define FMT_POL_BIT 5
`define FMT_EDGE_BIT 4
`define FMT_ORDER_BIT 3
`define FMT_SELECT_PIN_ENABLE_BIT 2
`define FMT_WRITE_COLLISION_FLAG_BIT 1
`define FMT_TRF_BIT 0
`define DIV4_HALF 8'h01
`define DIV16_HALF 8'h07
`define DIV64_HALF 8'h1F
`define BITS_PER_BYTE 4'h8
`endif

// *** verilog/spi_port_pkg.sv ***
// types shared by the serial port files
package spi_port_pkg;
    typedef enum logic [2:0]
    {
        MODE_SYS4, MODE_SYS16, MODE_SYS64, MODE_SUB, MODE_TMR, MODE_SLAVE, MODE_TWI, MODE_OFF
    } op_mode_t;
    typedef struct packed
    {
        logic sck;
        logic sdi;
        logic ss_n;
    } pin_in_t;
    typedef struct packed
    {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } pin_out_t;
endpackage

// *** verilog/shift_rate_gen.sv ***
// half-bit tick generator for master mode shift clock
`timescale 1ns/1ps
`include "spi_port_consts.svh"
module shift_rate_gen
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire spi_port_pkg::op_mode_t mode_i,
    input wire logic sub_tick_i,
    input wire logic tmr_tick_i,
    output logic half_tick_o
);
    logic [7:0] cnt_ff;
    logic [7:0] limit;
    logic cnt_hit;
    // each tick is one sck half period
    always_comb
    begin
        case (mode_i)
            spi_port_pkg::MODE_SYS4: limit = `DIV4_HALF;
            spi_port_pkg::MODE_SYS16: limit = `DIV16_HALF;
            spi_port_pkg::MODE_SYS64: limit = `DIV64_HALF;
            default: limit = 8'h00;
        endcase
    end
    assign cnt_hit = (cnt_ff >= limit);
    // counter restarts with each transfer so the first edge timing is fixed
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i || cnt_hit)
            cnt_ff <= 8'h00;
        else
            cnt_ff <= cnt_ff + 8'h01;
    end
    // sub clock and timer match give one half period per tick
    always_comb
    begin
        case (mode_i)
            spi_port_pkg::MODE_SUB: half_tick_o = run_i && sub_tick_i;
            spi_port_pkg::MODE_TMR: half_tick_o = run_i && tmr_tick_i;
            default: half_tick_o = run_i && cnt_hit;
        endcase
    end
endmodule

// *** verilog/wb_byte_regs.sv ***
// classic wishbone slave front end, one cycle ack
`timescale 1ns/1ps
module wb_byte_regs
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic sel_i,
    output logic ack_o,
    output logic wr_o,
    output logic rd_o
);
    logic ack_ff;
    // ack drops after one cycle so each access is taken once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= cyc_i && stb_i && !ack_ff;
    end
    assign ack_o = ack_ff;
    assign wr_o = ack_ff && we_i && sel_i && cyc_i && stb_i;
    assign rd_o = ack_ff && !we_i && cyc_i && stb_i;
endmodule

// *** dv/spi_port_asserts.sv ***
// checker for the spi port: bus handshake, pin levels and byte timing
`timescale 1ns/1ps
module spi_port_asserts
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire spi_port_pkg::pin_out_t pins_o,
    input wire logic ss_used_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] mode_ff;
    logic [7:0] fmt_ff;
    logic [7:0] blen_ff;
    logic [6:0] prev_ff;
    logic wr;
    logic mst;
    logic calm;
    assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign mst = mode_ff[1] && mode_ff[7:5] < 3'h5;
    // calm: nothing changed since the last edge, so registered outputs have caught up
    assign calm = prev_ff == {mode_ff[7:5], mode_ff[1], fmt_ff[5], fmt_ff[2], busy_o};
    ////////////////////////////////////////////////////////////////////////////////
    // shadow copies of the control bytes as written
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_ff <= 8'hE0;
        else if (wr && adr_i == 2'h1)
            mode_ff <= dat_i[7:0];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fmt_ff <= 8'h00;
        else if (wr && adr_i == 2'h2)
            fmt_ff <= dat_i[7:0];
    end
    // busy run length and last settings; no reset, both settle during reset
    always_ff @(posedge clk_i)
    begin
        blen_ff <= busy_o ? blen_ff + 8'h01 : 8'h00;
        prev_ff <= {mode_ff[7:5], mode_ff[1], fmt_ff[5], fmt_ff[2], busy_o};
    end
    ////////////////////////////////////////////////////////////////////////////////
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked next cycle");
    pins_off_a: assert property (calm && !mode_ff[1] |-> !pins_o.sck_oe && !pins_o.sdo_oe)
        else $error("pins driven while disabled");
    idle_pins_a: assert property (calm && mst && fmt_ff[2] && !busy_o |->
        pins_o.sck_oe && pins_o.sck_o == !fmt_ff[5] && pins_o.sdo_oe && pins_o.sdo_o)
        else $error("master idle pins wrong");
    slave_sck_a: assert property (calm && mode_ff[1] && mode_ff[7:5] == 3'h5 |->
        !pins_o.sck_oe) else $error("slave drives sck");
    start_a: assert property (wr && adr_i == 2'h0 && mst && !busy_o |-> ##[1:3] busy_o)
        else $error("master write did not start a byte");
    byte_len_a: assert property ($fell(busy_o) && mode_ff[7:5] == 3'h0 |->
        blen_ff >= 8'h1D && blen_ff <= 8'h23) else $error("div4 byte not 32 clocks");
    ss_used_a: assert property (calm |-> ss_used_o == (mode_ff[1] && fmt_ff[2]))
        else $error("select pin use flag wrong");
    cover property (wr && adr_i == 2'h0 && busy_o);
    cover property ($fell(busy_o) && mode_ff[7:5] == 3'h5);
    cover property (busy_o && mode_ff[7:5] == 3'h4);
endmodule
bind spi_port spi_port_asserts chk
(
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .pins_o(pins_o), .ss_used_o(ss_used_o),
    .busy_o(busy_o)
);

// *** dv/spi_peer.sv ***
// far side model: spi slave for master tests, spi master for slave tests
`timescale 1ns/1ps
module spi_peer
(
    input wire logic clk_i,
    input wire spi_port_pkg::pin_out_t dut_i,
    input wire logic [2:0] cfg_i,
    input wire logic load_i,
    input wire logic [7:0] tx_i,
    output spi_port_pkg::pin_in_t pins_o,
    output logic [7:0] rx_o
);
    // cfg_i is {idle level, capture edge, msb first}, as in the format byte
    logic m_sck = 1'h1;
    logic m_ss_n = 1'h1;
    logic prev_ff;
    logic seen_ff;
    logic [7:0] txs_ff;
    logic in_frame = 1'h0;
    logic sck_w;
    logic sdo_w;
    logic samp;
    // outside a frame our sck rests at the idle level; released sdo pulls high
    assign sck_w = dut_i.sck_oe ? dut_i.sck_o : (in_frame ? m_sck : !cfg_i[2]);
    assign sdo_w = dut_i.sdo_oe ? dut_i.sdo_o : 1'h1;
    assign samp = sck_w != prev_ff && (sck_w == (cfg_i[2] == cfg_i[1]));
    assign pins_o = {sck_w, cfg_i[0] ? txs_ff[7] : txs_ff[0], m_ss_n};
    ////////////////////////////////////////////////////////////////////////////////
    // no shift before the first capture, so both clock phases see bit one
    always_ff @(posedge clk_i)
    begin
        prev_ff <= sck_w;
        if (load_i)
        begin
            txs_ff <= tx_i;
            seen_ff <= 1'h0;
        end
        else if (samp)
        begin
            rx_o <= cfg_i[0] ? {rx_o[6:0], sdo_w} : {sdo_w, rx_o[7:1]};
            seen_ff <= 1'h1;
        end
        else if (sck_w != prev_ff && seen_ff)
            txs_ff <= cfg_i[0] ? {txs_ff[6:0], 1'h0} : {1'h0, txs_ff[7:1]};
    end
    // master frame: select, then slow edges, then release; clock still outside
    task automatic frame(input int edges, input logic use_ss);
        @(posedge clk_i);
        m_sck <= !cfg_i[2];
        in_frame <= 1'h1;
        m_ss_n <= !use_ss;
        repeat (8) @(posedge clk_i);
        repeat (edges)
        begin
            m_sck <= !m_sck;
            repeat (8) @(posedge clk_i);
        end
        m_ss_n <= 1'h1;
        repeat (8) @(posedge clk_i);
        in_frame <= 1'h0;
    endtask
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the spi port: registers, master and slave bytes
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [1:0] adr = 2'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic sub_t = 1'h0;
    logic tmr_t = 1'h0;
    logic [3:0] tick_ff = 4'h0;
    spi_port_pkg::pin_in_t pins_i;
    spi_port_pkg::pin_out_t pins_o;
    logic ss_used_o;
    logic busy_o;
    logic [2:0] cfg = 3'h0;
    logic p_ld = 1'h0;
    logic [7:0] p_tx = 8'h00;
    logic [7:0] p_rx;
    logic [7:0] q;
    logic [31:0] seed = 32'h00000027;
    int num_errors = 0;
    int checks_done = 0;
    spi_port dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .sub_tick_i(sub_t),
        .tmr_tick_i(tmr_t), .pins_i(pins_i), .pins_o(pins_o), .ss_used_o(ss_used_o),
        .busy_o(busy_o)
    );
    spi_peer peer
    (
        .clk_i(clk_i), .dut_i(pins_o), .cfg_i(cfg), .load_i(p_ld), .tx_i(p_tx),
        .pins_o(pins_i), .rx_o(p_rx)
    );
    initial
    begin
        forever #5 clk_i = !clk_i;
    end
    // sub clock every 3, timer match every 5 clocks, so the two modes differ
    always @(posedge clk_i)
    begin
        tick_ff <= (tick_ff == 4'hE) ? 4'h0 : tick_ff + 4'h1;
        sub_t <= tick_ff % 3 == 0;
        tmr_t <= tick_ff % 5 == 0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] fmt_of(input logic [2:0] c, input logic cs, input logic [1:0] f);
        return {2'h0, c, cs, f};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic stop_if(input logic late);
        if (late)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h000000, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'h1 && n < 20);
        q = dat_o[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
        stop_if(n >= 20);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(posedge clk_i);
        while (busy_o !== 1'h0 && n < 3000)
        begin
            @(posedge clk_i);
            n++;
        end
        stop_if(n >= 3000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] tx;
        logic [7:0] dtx;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, 2'h1, 8'h00);
        chk(q, 8'hE0);
        wb(1'h0, 2'h0, 8'h00);
        chk(q, 8'h00);
        wb(1'h1, 2'h1, 8'hFC);
        wb(1'h0, 2'h1, 8'h00);
        chk(q, 8'hEC);
        wb(1'h1, 2'h2, 8'hC0);
        wb(1'h0, 2'h2, 8'h00);
        chk(q, 8'hC0);
        wb(1'h1, 2'h3, 8'h5A);
        wb(1'h0, 2'h3, 8'h00);
        chk(q, 8'h00);
        $display("test registers done");
        // every clock source and every idle level, edge and order combination
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            tx = seed[7:0];
            dtx = seed[15:8];
            cfg <= 3'(i);
            wb(1'h1, 2'h2, fmt_of(3'(i), i[1], 2'h0));
            p_tx <= tx;
            p_ld <= 1'h1;
            wb(1'h1, 2'h1, {3'(i % 5), 5'h02});
            p_ld <= 1'h0;
            wb(1'h1, 2'h0, dtx);
            wb(1'h1, 2'h0, ~dtx);
            wait_idle();
            wb(1'h0, 2'h2, 8'h00);
            chk(q, fmt_of(3'(i), i[1], 2'h3));
            wb(1'h0, 2'h0, 8'h00);
            chk(q, tx);
            chk(p_rx, dtx);
            wb(1'h1, 2'h2, fmt_of(3'(i), i[1], 2'h0));
            wb(1'h0, 2'h2, 8'h00);
            chk(q, fmt_of(3'(i), i[1], 2'h0));
        end
        $display("test master done");
        // slave: full byte, byte cut short by select, full byte without select pin
        cfg <= 3'h5;
        for (int j = 0; j < 3; j++)
        begin
            seed = xs(seed);
            tx = seed[7:0];
            dtx = seed[15:8];
            wb(1'h1, 2'h1, 8'hA2);
            wb(1'h1, 2'h2, fmt_of(3'h5, j != 2, 2'h0));
            wb(1'h1, 2'h0, dtx);
            p_tx <= tx;
            p_ld <= 1'h1;
            @(posedge clk_i);
            p_ld <= 1'h0;
            peer.frame(j == 1 ? 6 : 16, j != 2);
            wb(1'h0, 2'h1, 8'h00);
            chk(q, 8'hA2 | {7'h00, j == 1});
            wb(1'h0, 2'h2, 8'h00);
            chk(q, fmt_of(3'h5, j != 2, 2'h1));
            wb(1'h0, 2'h0, 8'h00);
            if (j != 1)
            begin
                chk(q, tx);
                chk(p_rx, dtx);
            end
        end
        $display("test slave done");
        wb(1'h1, 2'h2, 8'h28);
        wb(1'h1, 2'h1, 8'hA3);
        wb(1'h0, 2'h2, 8'h00);
        chk(q, 8'h28);
        wb(1'h1, 2'h1, 8'hA0);
        repeat (4) @(posedge clk_i);
        wb(1'h1, 2'h1, 8'hA2);
        wb(1'h0, 2'h2, 8'h00);
        chk(q, 8'h28);
        $display("test enable done");
        report_and_stop();
    end
endmodule
